// ### core/trl_link.sv
`timescale 1ns/1ps
// Operation
// - Encoder sends nine digits per word, one per code input, in order.
// - Each request sends two identical words, finished even if released early.
// - Request held low keeps the encoder repeating word pairs.
// - Zero is short-short, one is long-long, open is long-short.
// - Inputs are weakly driven low then high to classify zero, one, open.
// - Request high keeps the encoder idle with its oscillator stopped.
// - Request fall starts oscillator, resets sequence, probes and shifts out.
// - Output stays idle for three digit periods between paired words.
// - Data decoder compares first five digits to the local address.
// - Matching data equal to last valid data raises valid at ninth digit.
// - Second word rechecked; agreeing data loads and holds the four outputs.
// - Valid drops on a bad digit or four idle digit periods.
// - An open digit in the data field decodes as one.
// - Address-only variant compares all nine digits, valid flag only.
// - Ninth local digit is binary; one versus open shortens valid.
// - Valid may rise before both words of a pair are received.
// - Pulses longer than 1.72 transmit periods count as long.
// - Input low for 33.5 transmit periods means end of transmission.
// - Input low for 0.4 of that time marks the gap between words.
// - An external clock may drive the oscillator input instead.
module trl_link (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    // Encoder pins
    input  wire logic                tx_request_n,
    input  wire logic                osc_clock_input,
    input  wire logic                osc_ext_select,
    input  wire logic [8:0]          code_inputs,
    output trl_pkg::trl_drive_t      code_drive,
    output logic                     tx_data_out,
    // Decoder pins
    input  wire logic                rx_data_in,
    input  wire logic                address_only_mode,
    input  wire logic [8:0][1:0]     local_address_inputs,
    output logic                     word_valid_flag,
    output logic [3:0]               decoded_outputs
);
    import trl_pkg::*;

    localparam int PIN_W = 32;

    // Two-stage synchroniser for every pin input
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_reg <= {PIN_W{1'b0}};
            pin_sync_reg <= {PIN_W{1'b0}};
        end else if (clk_en) begin
            pin_meta_reg <= {tx_request_n, osc_clock_input, osc_ext_select,
                             code_inputs, rx_data_in, address_only_mode,
                             local_address_inputs};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic            req_n_s;
    logic            osc_s;
    logic            ext_sel_s;
    logic [8:0]      code_s;
    logic            rx_s;
    logic            addr_only_s;
    logic [8:0][1:0] local_s;

    assign {req_n_s, osc_s, ext_sel_s, code_s, rx_s, addr_only_s,
            local_s} = pin_sync_reg;

    trl_encoder u_encoder (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .tx_req_n_s  (req_n_s),
        .osc_ext_sel (ext_sel_s),
        .osc_ext_s   (osc_s),
        .code_in_s   (code_s),
        .code_drive  (code_drive),
        .data_out    (tx_data_out)
    );

    // Pulse width and idle time measurement
    logic             rx_prev_reg;
    logic [CNT_W-1:0] high_cnt_reg;
    logic [CNT_W-1:0] low_cnt_reg;
    logic             rise_ev;
    logic             fall_ev;
    logic             pulse_long;
    logic             gap_hit;
    logic             eot_hit;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_prev_reg  <= 1'b0;
            high_cnt_reg <= '0;
            low_cnt_reg  <= '0;
        end else if (clk_en) begin
            rx_prev_reg <= rx_s;
            if (rx_s) begin
                low_cnt_reg  <= '0;
                high_cnt_reg <= rx_prev_reg ? high_cnt_reg + 12'h001
                                            : 12'h001;
            end else if (low_cnt_reg != 12'(EOT_CYC)) begin
                low_cnt_reg <= low_cnt_reg + 12'h001;
            end
        end
    end

    always_comb begin
        rise_ev    = rx_s && !rx_prev_reg;
        fall_ev    = !rx_s && rx_prev_reg;
        pulse_long = high_cnt_reg >= 12'(THRESH_CYC);
        gap_hit    = !rx_s && low_cnt_reg == 12'(GAP_CYC);
        eot_hit    = !rx_s && low_cnt_reg == 12'(EOT_CYC);
    end

    // Digit assembly and comparison
    logic        half_reg;
    logic        p0_reg;
    logic [3:0]  digit_reg;
    logic        word_idx_reg;
    logic        err_reg;
    logic [3:0]  data_reg;
    logic [3:0]  stored_reg;
    logic [3:0]  out_reg;
    logic        valid_reg;
    logic        short_on_reg;
    logic [CNT_W-1:0] short_cnt_reg;

    logic [1:0]  rx_trit;
    logic        rx_bad;
    logic        is_addr;
    logic        last9;
    logic        digit_end;
    logic        digit_err;
    logic        shorten_ev;
    logic        eval_ev;
    logic        last9_ok;
    logic        short_done;

    always_comb begin
        unique case ({p0_reg, pulse_long})
            2'b11:   rx_trit = TRL_ONE;
            2'b10:   rx_trit = TRL_OPEN;
            default: rx_trit = TRL_ZERO;
        endcase
        rx_bad    = !p0_reg && pulse_long;
        is_addr   = addr_only_s ? (digit_reg < 4'(ADDR_LEN_ONLY))
                                : (digit_reg < 4'(ADDR_LEN_DATA));
        last9     = addr_only_s && digit_reg == 4'(NDIG - 1);
        digit_end = fall_ev && half_reg && digit_reg < 4'(NDIG);
        digit_err = digit_end && (rx_bad || (is_addr && !last9 &&
                    rx_trit != local_s[digit_reg]));
        shorten_ev = digit_end && last9 && !rx_bad &&
                     ((rx_trit == TRL_ONE && local_s[8] == TRL_OPEN) ||
                      (rx_trit == TRL_OPEN && local_s[8] == TRL_ONE));
        // Second rising edge of the ninth digit
        eval_ev   = rise_ev && half_reg &&
                    digit_reg == 4'(NDIG - 1) && !err_reg;
        last9_ok  = p0_reg == (local_s[8] != TRL_ZERO);
        short_done = short_on_reg && short_cnt_reg == 12'(THRESH_CYC);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            half_reg     <= 1'b0;
            p0_reg       <= 1'b0;
            digit_reg    <= 4'h0;
            word_idx_reg <= 1'b0;
            err_reg      <= 1'b0;
            data_reg     <= 4'h0;
        end else if (clk_en) begin
            if (gap_hit || eot_hit) begin
                half_reg     <= 1'b0;
                digit_reg    <= 4'h0;
                err_reg      <= 1'b0;
                // Only a complete first word opens the second one
                word_idx_reg <= !eot_hit && !word_idx_reg &&
                                digit_reg == 4'(NDIG);
            end else if (fall_ev && digit_reg < 4'(NDIG)) begin
                if (!half_reg) begin
                    half_reg <= 1'b1;
                    p0_reg   <= pulse_long;
                    // Long first pulse means one or open: both read as one
                    if (!addr_only_s && !is_addr)
                        data_reg[2'(digit_reg - 4'(ADDR_LEN_DATA))]
                            <= pulse_long;
                end else begin
                    half_reg  <= 1'b0;
                    digit_reg <= digit_reg + 4'h1;
                    err_reg   <= err_reg || digit_err;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            short_on_reg  <= 1'b0;
            short_cnt_reg <= '0;
        end else if (clk_en) begin
            if (eot_hit || short_done) begin
                short_on_reg <= 1'b0;
            end else if (shorten_ev && valid_reg) begin
                short_on_reg  <= 1'b1;
                short_cnt_reg <= '0;
            end else if (short_on_reg) begin
                short_cnt_reg <= short_cnt_reg + 12'h001;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            valid_reg  <= 1'b0;
            stored_reg <= 4'h0;
            out_reg    <= 4'h0;
        end else if (clk_en) begin
            if (eot_hit || digit_err || short_done) begin
                valid_reg <= 1'b0;
            end else if (eval_ev) begin
                if (addr_only_s) begin
                    valid_reg <= last9_ok;
                end else if (!word_idx_reg) begin
                    // First word alone may raise valid
                    stored_reg <= data_reg;
                    valid_reg  <= data_reg == out_reg;
                end else if (data_reg == stored_reg) begin
                    out_reg   <= data_reg;
                    valid_reg <= 1'b1;
                end else begin
                    valid_reg <= 1'b0;
                end
            end
        end
    end

    assign word_valid_flag = valid_reg;
    assign decoded_outputs = out_reg;

    a_eot_drops_valid: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && eot_hit |=> !valid_reg)
        else $error("valid held past end of transmission");

    a_err_drops_valid: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && digit_err |=> !valid_reg && err_reg)
        else $error("valid held after bad digit");

    a_gap_resets_word: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && gap_hit |=> digit_reg == 4'h0 && !half_reg && !err_reg)
        else $error("digit state not cleared at gap");

    a_out_only_on_pair: assert property (@(posedge clock)
        disable iff (sys_rst)
        $changed(out_reg) |-> $past(eval_ev && word_idx_reg && !addr_only_s))
        else $error("outputs changed without second word");

    a_valid_has_cause: assert property (@(posedge clock)
        disable iff (sys_rst)
        $rose(valid_reg) |-> $past(eval_ev))
        else $error("valid rose without ninth digit");

    a_open_reads_one: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && fall_ev && !half_reg && pulse_long && !addr_only_s &&
        digit_reg == 4'(ADDR_LEN_DATA) && !gap_hit && !eot_hit
            |=> data_reg[0])
        else $error("long first pulse not stored as one");

    a_gap_opens_second: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && gap_hit && !word_idx_reg && digit_reg == 4'(NDIG)
            |=> word_idx_reg)
        else $error("gap after full word did not open second word");

    a_eot_restarts_word: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && eot_hit |=> !word_idx_reg && digit_reg == 4'h0 && !half_reg)
        else $error("end of transmission did not restart word");

    a_long_threshold: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && fall_ev && !half_reg && digit_reg < 4'(NDIG)
            |=> p0_reg == (high_cnt_reg >= 12'(THRESH_CYC)))
        else $error("first pulse width misclassified");

    a_short_ends_valid: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && short_done |=> !valid_reg && !short_on_reg)
        else $error("shortened valid pulse not ended");

    a_first_word_stores: assert property (@(posedge clock)
        disable iff (sys_rst)
        clk_en && eval_ev && !word_idx_reg && !addr_only_s && !eot_hit &&
        !digit_err && !short_done
            |=> stored_reg == $past(data_reg))
        else $error("first word data not stored");

endmodule : trl_link

// ### core/trl_pkg.sv
package trl_pkg;

    // Clock and oscillator rates
    localparam int CLK_HZ  = 40_000_000;
    localparam int OSC_HZ  = 400_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;

    // Word layout
    localparam int NDIG          = 9;
    localparam int ADDR_LEN_DATA = 5;
    localparam int ADDR_LEN_ONLY = 9;
    localparam int DATA_BITS     = 4;

    // Encoder pulse shape, in oscillator periods
    localparam int SLOT_TICKS  = 4;
    localparam int SHORT_TICKS = 1;
    localparam int LONG_TICKS  = 3;
    localparam int GAP_DIGITS  = 3;
    localparam int GAP_TICKS   = GAP_DIGITS * 2 * SLOT_TICKS;

    // Decoder decision times, in transmit clock periods (scaled)
    localparam int THRESH_X100 = 172;
    localparam int EOT_X10     = 335;
    localparam int GAP_FRAC_X10 = 4;
    localparam int THRESH_CYC  = (OSC_DIV * THRESH_X100) / 100;
    localparam int EOT_CYC     = (OSC_DIV * EOT_X10) / 10;
    localparam int GAP_CYC     = (EOT_CYC * GAP_FRAC_X10) / 10;
    localparam int CNT_W       = 12;

    typedef enum logic [1:0] {
        TRL_ZERO = 2'h0,
        TRL_ONE  = 2'h1,
        TRL_OPEN = 2'h2
    } trl_trit_t;

    typedef enum logic [1:0] {
        ENC_IDLE  = 2'h0,
        ENC_PROBE = 2'h1,
        ENC_SEND  = 2'h3,
        ENC_GAP   = 2'h2
    } trl_enc_state_t;

    // Weak drive applied to the code inputs while probing
    typedef struct packed {
        logic [NDIG-1:0] oe;
        logic [NDIG-1:0] val;
    } trl_drive_t;

endpackage : trl_pkg

// ### core/trl_encoder.sv
`timescale 1ns/1ps
module trl_encoder (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    // Synchronised pins
    input  wire logic                tx_req_n_s,
    input  wire logic                osc_ext_sel,
    input  wire logic                osc_ext_s,
    input  wire logic [8:0]          code_in_s,
    // Outputs
    output trl_pkg::trl_drive_t      code_drive,
    output logic                     data_out
);
    import trl_pkg::*;

    trl_enc_state_t  state_reg;
    logic [7:0]      div_reg;
    logic            osc_prev_reg;
    logic            tick;
    logic [3:0]      digit_reg;
    logic            slot_reg;
    logic [1:0]      sub_reg;
    logic [4:0]      gap_reg;
    logic            word_reg;
    logic            low_res_reg;
    logic [8:0][1:0] trits_reg;

    function automatic logic [1:0] pulse_ticks(input logic [1:0] t,
                                               input logic second);
        logic long_p;
        long_p = (t == TRL_ONE) || ((t == TRL_OPEN) && !second);
        return long_p ? 2'(LONG_TICKS) : 2'(SHORT_TICKS);
    endfunction : pulse_ticks

    // Oscillator runs only outside idle; external clock may replace it
    always_comb begin
        tick = (state_reg != ENC_IDLE) &&
               (osc_ext_sel ? (osc_ext_s && !osc_prev_reg)
                            : (div_reg == 8'(OSC_DIV - 1)));
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg      <= 8'h00;
            osc_prev_reg <= 1'b0;
        end else if (clk_en) begin
            osc_prev_reg <= osc_ext_s;
            if (state_reg == ENC_IDLE || div_reg == 8'(OSC_DIV - 1))
                div_reg <= 8'h00;
            else
                div_reg <= div_reg + 8'h01;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg   <= ENC_IDLE;
            digit_reg   <= 4'h0;
            slot_reg    <= 1'b0;
            sub_reg     <= 2'h0;
            gap_reg     <= 5'h00;
            word_reg    <= 1'b0;
            low_res_reg <= 1'b0;
            trits_reg   <= '0;
            code_drive  <= '0;
            data_out    <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == ENC_IDLE) begin
                code_drive <= '0;
                data_out   <= 1'b0;
                if (!tx_req_n_s) begin
                    state_reg <= ENC_PROBE;
                    digit_reg <= 4'h0;
                    sub_reg   <= 2'h0;
                    slot_reg  <= 1'b0;
                    word_reg  <= 1'b0;
                end
            end else if (tick) begin
                unique case (state_reg)
                    ENC_PROBE: begin
                        sub_reg <= sub_reg + 2'h1;
                        if (sub_reg == 2'h0) begin
                            code_drive.oe[digit_reg]  <= 1'b1;
                            code_drive.val[digit_reg] <= 1'b0;
                        end else if (sub_reg == 2'h1) begin
                            low_res_reg <= code_in_s[digit_reg];
                            code_drive.val[digit_reg] <= 1'b1;
                        end else begin
                            sub_reg <= 2'h0;
                            code_drive <= '0;
                            if (low_res_reg)
                                trits_reg[digit_reg] <= TRL_ONE;
                            else if (!code_in_s[digit_reg])
                                trits_reg[digit_reg] <= TRL_ZERO;
                            else
                                trits_reg[digit_reg] <= TRL_OPEN;
                            if (digit_reg == 4'(NDIG - 1)) begin
                                state_reg <= ENC_SEND;
                                digit_reg <= 4'h0;
                            end else begin
                                digit_reg <= digit_reg + 4'h1;
                            end
                        end
                    end
                    ENC_SEND: begin
                        data_out <= sub_reg <
                            pulse_ticks(trits_reg[digit_reg], slot_reg);
                        sub_reg  <= sub_reg + 2'h1;
                        if (sub_reg == 2'(SLOT_TICKS - 1)) begin
                            slot_reg <= !slot_reg;
                            if (slot_reg) begin
                                if (digit_reg == 4'(NDIG - 1)) begin
                                    state_reg <= ENC_GAP;
                                    gap_reg   <= 5'h00;
                                end else begin
                                    digit_reg <= digit_reg + 4'h1;
                                end
                            end
                        end
                    end
                    ENC_GAP: begin
                        data_out <= 1'b0;
                        gap_reg  <= gap_reg + 5'h01;
                        if (gap_reg == 5'(GAP_TICKS - 1)) begin
                            digit_reg <= 4'h0;
                            sub_reg   <= 2'h0;
                            slot_reg  <= 1'b0;
                            if (!word_reg) begin
                                word_reg  <= 1'b1;
                                state_reg <= ENC_SEND;
                            end else if (!tx_req_n_s) begin
                                word_reg  <= 1'b0;
                                state_reg <= ENC_PROBE;
                            end else begin
                                state_reg <= ENC_IDLE;
                            end
                        end
                    end
                    default: state_reg <= ENC_IDLE;
                endcase
            end
        end
    end

    a_idle_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        (state_reg == ENC_IDLE && $past(state_reg) == ENC_IDLE)
            |-> !data_out && div_reg == 8'h00)
        else $error("encoder active while idle");

    a_gap_after_nine: assert property (@(posedge clock)
        disable iff (sys_rst)
        $rose(state_reg == ENC_GAP) |-> $past(digit_reg) == 4'h8)
        else $error("word did not hold nine digits");

    a_pair_complete: assert property (@(posedge clock)
        disable iff (sys_rst)
        (state_reg == ENC_IDLE && $past(state_reg) == ENC_GAP)
            |-> $past(word_reg))
        else $error("encoder stopped before second word");

endmodule : trl_encoder

// ### test/trl_far_end.sv
`timescale 1ns/1ps
module trl_far_end (
    // Clock
    input  wire logic                clock,
    // Pin wiring and weak drive
    input  trl_pkg::trl_trit_t [8:0] pin_mode,
    input  trl_pkg::trl_drive_t      code_drive,
    // Sensed pin levels
    output logic [8:0]               code_inputs
);
    import trl_pkg::*;

    logic [8:0] last_reg;

    always @(posedge clock) begin
        last_reg <= code_inputs;
    end

    // An open pin left undriven drifts, so it shows its last level inverted
    always_comb begin
        for (int i = 0; i < NDIG; i++) begin
            case (pin_mode[i])
                TRL_ZERO: code_inputs[i] = 1'b0;
                TRL_ONE:  code_inputs[i] = 1'b1;
                default:  code_inputs[i] = code_drive.oe[i] ?
                              code_drive.val[i] : ~last_reg[i];
            endcase
        end
    end
endmodule : trl_far_end

// ### test/trinary_remote_code_link_tb.sv
`timescale 1ns/1ps
module trinary_remote_code_link_tb;
    import trl_pkg::*;

    logic                clock;
    logic                sys_rst;
    logic                tx_request_n;
    logic                address_only_mode;
    trl_trit_t [8:0]     pin_mode;
    logic [8:0]          code_inputs;
    logic [8:0][1:0]     local_address_inputs;
    trl_drive_t          code_drive;
    logic                tx_data_out;
    logic                word_valid_flag;
    logic [3:0]          decoded_outputs;
    logic                tx_prev;
    logic                osc_clk;
    logic                osc_sel;
    int                  osc_cnt;
    logic                seen_v;
    int                  n_fail;
    int                  compares;
    int                  n_pul;
    int                  run;
    int                  hi_w[256];
    int                  lo_w[256];

    trl_link i_dut (
        .clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
        .tx_request_n(tx_request_n), .osc_clock_input(osc_clk),
        .osc_ext_select(osc_sel), .code_inputs(code_inputs),
        .code_drive(code_drive), .tx_data_out(tx_data_out),
        .rx_data_in(tx_data_out), .address_only_mode(address_only_mode),
        .local_address_inputs(local_address_inputs),
        .word_valid_flag(word_valid_flag),
        .decoded_outputs(decoded_outputs)
    );

    trl_far_end i_far (
        .clock(clock), .pin_mode(pin_mode), .code_drive(code_drive),
        .code_inputs(code_inputs)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // External oscillator, 100 clocks per period like the internal one
    always @(posedge clock) begin
        osc_cnt <= (osc_cnt == 49) ? 0 : osc_cnt + 1;
        if (osc_cnt == 49) osc_clk <= ~osc_clk;
    end

    // Record high widths and the low time before each pulse, in clocks
    always @(posedge clock) begin
        if (word_valid_flag === 1'b1) seen_v = 1'b1;
        if (tx_data_out !== tx_prev) begin
            if (tx_prev === 1'b1) begin
                hi_w[n_pul] = run;
                n_pul++;
            end else begin
                lo_w[n_pul] = run;
            end
            run = 1;
        end else begin
            run++;
        end
        tx_prev = tx_data_out;
    end

    task automatic finish_test();
        $display("Compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check_val

    task automatic wait_pulses(input int target);
        int k;
        k = 0;
        while (n_pul < target && k < 40000) begin
            @(posedge clock);
            k++;
        end
        check_val(n_pul[11:0], target[11:0]);
        if (n_pul < target) finish_test();
    endtask : wait_pulses

    task automatic check_word(input int b, input int w);
        int p;
        for (int d = 0; d < NDIG; d++) begin
            p = b + w * 18 + 2 * d;
            check_val(hi_w[p], (pin_mode[d] != TRL_ZERO) ? 300 : 100);
            check_val(hi_w[p + 1], (pin_mode[d] == TRL_ONE) ? 300 : 100);
            check_val(hi_w[p] + lo_w[p + 1], 400);
            if (w == 1 && d == 0)
                check_val(hi_w[p - 1] + lo_w[p], 2800);
        end
    endtask : check_word

    task automatic pulse_request();
        tx_request_n <= 1'b0;
        repeat (4) @(posedge clock);
        tx_request_n <= 1'b1;
    endtask : pulse_request

    task automatic idle_check(input int target);
        repeat (4000) @(posedge clock);
        check_val(word_valid_flag, 1'b0);
        check_val(n_pul[11:0], target[11:0]);
        check_val(code_drive.oe, 12'h0);
    endtask : idle_check

    task automatic scen_data();
        int b;
        b = n_pul;
        address_only_mode <= 1'b0;
        pulse_request();
        wait_pulses(b + 36);
        check_word(b, 0);
        check_word(b, 1);
        check_val(word_valid_flag, 1'b1);
        check_val(decoded_outputs, 12'h5);
        idle_check(b + 36);
        check_val(decoded_outputs, 12'h5);
    endtask : scen_data

    task automatic scen_addr_bad();
        int b;
        b = n_pul;
        address_only_mode <= 1'b1;
        local_address_inputs[3] <= 2'h1;
        seen_v = 1'b0;
        pulse_request();
        wait_pulses(b + 36);
        check_val(seen_v, 1'b0);
        idle_check(b + 36);
        local_address_inputs[3] <= 2'h0;
    endtask : scen_addr_bad

    task automatic scen_addr_hold();
        int b;
        b = n_pul;
        osc_sel <= 1'b1;
        tx_request_n <= 1'b0;
        wait_pulses(b + 18);
        check_val(word_valid_flag, 1'b1);
        wait_pulses(b + 54);
        tx_request_n <= 1'b1;
        check_word(b + 36, 0);
        wait_pulses(b + 72);
        idle_check(b + 72);
    endtask : scen_addr_hold

    initial begin
        n_fail = 0;
        compares = 0;
        n_pul = 0;
        run = 0;
        osc_clk = 1'b0;
        osc_sel = 1'b0;
        osc_cnt = 0;
        tx_prev = 1'b0;
        seen_v = 1'b0;
        sys_rst = 1'b1;
        tx_request_n = 1'b1;
        address_only_mode = 1'b0;
        pin_mode = {TRL_ZERO, TRL_ONE, TRL_ZERO, TRL_OPEN, TRL_ONE,
                    TRL_ZERO, TRL_OPEN, TRL_ONE, TRL_ZERO};
        for (int i = 0; i < NDIG; i++) local_address_inputs[i] = pin_mode[i];
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        scen_data();
        scen_addr_bad();
        scen_addr_hold();
        finish_test();
    end
endmodule : trinary_remote_code_link_tb
